// [include/pcrs_pkg.sv]
// Constants, register map and operation codes of the program counter and return stack block.
// Assumes a single 100 MHz core clock and an AXI4-Lite register bus with 32-bit data.
package pcrs_pkg;
	localparam int PCRS_PC_W = 21;
	localparam int PCRS_SP_W = 5;
	localparam int PCRS_EXT_W = 20;
	localparam int PCRS_ADDR_W = 8;
	localparam logic [PCRS_SP_W-1:0] PCRS_SP_ZERO = 5'h00;
	localparam logic [PCRS_SP_W-1:0] PCRS_SP_TOP = 5'h1f;
	localparam logic [PCRS_SP_W-1:0] PCRS_SP_ONE = 5'h01;
	localparam logic [PCRS_PC_W-1:0] PCRS_PC_STEP = 21'h000002;
	localparam logic [PCRS_PC_W-1:0] PCRS_PC_ZERO = 21'h000000;
	// Register byte offsets.
	localparam logic [PCRS_ADDR_W-1:0] PCRS_OFS_CFG = 8'h00;
	localparam logic [PCRS_ADDR_W-1:0] PCRS_OFS_MEMCTL = 8'h04;
	localparam logic [PCRS_ADDR_W-1:0] PCRS_OFS_PCL = 8'h08;
	localparam logic [PCRS_ADDR_W-1:0] PCRS_OFS_LATH = 8'h0c;
	localparam logic [PCRS_ADDR_W-1:0] PCRS_OFS_LATU = 8'h10;
	localparam logic [PCRS_ADDR_W-1:0] PCRS_OFS_SPTR = 8'h14;
	localparam logic [PCRS_ADDR_W-1:0] PCRS_OFS_TOSL = 8'h18;
	localparam logic [PCRS_ADDR_W-1:0] PCRS_OFS_TOSH = 8'h1c;
	localparam logic [PCRS_ADDR_W-1:0] PCRS_OFS_TOSU = 8'h20;
	localparam logic [PCRS_ADDR_W-1:0] PCRS_OFS_STKCFG = 8'h24;
	// Field positions and reset values.
	localparam int PCRS_CFG_WAIT = 7;
	localparam int PCRS_CFG_BW = 6;
	localparam int PCRS_CFG_EMB_LO = 4;
	localparam int PCRS_CFG_SHIFT = 3;
	localparam logic [7:0] PCRS_CFG_RST = 8'hf8;
	localparam logic [7:0] PCRS_CFG_MASK = 8'hf8;
	localparam int PCRS_MEMCTL_WAIT_LO = 4;
	localparam logic [7:0] PCRS_MEMCTL_MASK = 8'h30;
	localparam int PCRS_SPTR_FULL = 7;
	localparam int PCRS_SPTR_UNF = 6;
	localparam logic PCRS_STACK_OVERFLOW_RESET_ENABLE_RST = 1'b1;
	localparam logic [4:0] PCRS_LATU_MASK = 5'h1f;
	// Memory bus configuration field codes.
	localparam logic [1:0] PCRS_EMB_INT = 2'b11;
	localparam logic [1:0] PCRS_EMB_A12 = 2'b10;
	localparam logic [1:0] PCRS_EMB_A16 = 2'b01;
	localparam logic [PCRS_EXT_W-1:0] PCRS_MASK_A12 = 20'h00fff;
	localparam logic [PCRS_EXT_W-1:0] PCRS_MASK_A16 = 20'h0ffff;
	localparam logic [PCRS_EXT_W-1:0] PCRS_MASK_A20 = 20'hfffff;
	localparam logic [1:0] PCRS_RESP_OKAY = 2'b00;
	localparam logic [1:0] PCRS_RESP_SLVERR = 2'b10;
	typedef enum logic [2:0] {
		PCRS_OP_NONE = 3'h0,
		PCRS_OP_SEQ = 3'h1,
		PCRS_OP_JUMP = 3'h2,
		PCRS_OP_CALL = 3'h3,
		PCRS_OP_IRQ = 3'h4,
		PCRS_OP_RET = 3'h5,
		PCRS_OP_LINK = 3'h6
	} pcrs_op_t;
endpackage : pcrs_pkg

// [src/pcrs_top.sv]
// Program counter, fetch address steering and 31-level return stack with AXI4-Lite registers.
// Assumes the core issues one operation per cycle on op and that reset is synchronous.
// Operation
// - Internal-only mode reads above on-chip top return zero, a no-operation.
// - Config field 11 internal-only; 10, 01, 00 extended with 12, 16, 20 bits.
// - Extended mode fetches on-chip up to top, external above, automatically.
// - Extended mode allows all access both memories; internal-only blocks external.
// - Config bit 7 one disables waits; zero enables, count from memory control bits 5:4.
// - Config bit 6 one selects 16-bit data bus, zero 8-bit.
// - Shift bit 3 subtracts on-chip size from external address; clear drives counter.
// - Config bits 7:3 write-once reading one unprogrammed; bits 2:0 read zero.
// - Internal-only mode is default and sole mode without external bus.
// - Counter is 21 bits; low byte accessible, upper bytes only through latches.
// - Writing the low byte copies both latches into counter upper bits.
// - Reading the low byte copies counter upper bits into both latches.
// - Counter bit 0 stays zero except after a return to a top entry that software wrote odd; sequential step is two.
// - Call, relative call, goto, branch load counter directly without latches.
// - Push on calls and interrupt; pop on returns and enabled link instructions.
// - Calls and returns leave both latches unchanged.
// - Stack is 31 entries of 21 bits with a 5-bit pointer.
// - Push increments pointer first, then writes the addressed entry.
// - Pop loads counter from addressed entry, then decrements pointer.
// - Pointer resets to zero; zero has no entry behind it.
// - Pointer and top entry are software readable and writable.
// - Flags report stack full, overflow and underflow.
// - Full flag sets after 31 pushes; cleared by software or power-on reset.
// - Without overflow reset, pointer stops at 31, no overwrite; with it, reset requested.
// - Pop at zero returns zero, sets underflow, pointer stays zero.
// - Pointer register: full bit 7, underflow bit 6, pointer bits 4:0.
`timescale 1ns/100ps
`default_nettype none
module pcrs_top #(
	parameter logic [20:0] ONCHIP_BYTES = 21'h010000,
	parameter bit HAS_EXT_BUS = 1'b1
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic srst,
	input wire logic por,
	// Core operation port.
	input wire pcrs_pkg::pcrs_op_t op,
	input wire logic [pcrs_pkg::PCRS_PC_W-1:0] op_target,
	input wire logic ext_set_en,
	input wire logic tbl_req,
	input wire logic [pcrs_pkg::PCRS_PC_W-1:0] tbl_addr,
	// Fetch and external bus steering.
	output logic [pcrs_pkg::PCRS_PC_W-1:0] pc_out_r,
	output logic fetch_ext_r,
	output logic fetch_nop_r,
	output logic [pcrs_pkg::PCRS_EXT_W-1:0] ext_addr_r,
	output logic ext_bus_en_r,
	output logic bus16_r,
	output logic wait_en_r,
	output logic [1:0] wait_cnt_r,
	output logic tbl_ext_r,
	output logic tbl_blocked_r,
	output logic stack_reset_req_r,
	// AXI4-Lite slave.
	input wire logic [pcrs_pkg::PCRS_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [pcrs_pkg::PCRS_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import pcrs_pkg::*;

	logic [PCRS_PC_W-1:0] stk [1:31];
	logic [PCRS_PC_W-1:0] pc_r, pc_nxt;
	logic [PCRS_SP_W-1:0] sp_r, sp_nxt;
	logic full_r, full_nxt, unf_r, unf_nxt, rstq_nxt;
	logic [7:0] lath_r, lath_nxt;
	logic [4:0] latu_r, latu_nxt;
	logic [7:0] cfg_r, cfg_nxt;
	logic cfg_done_r, cfg_done_nxt;
	logic [7:0] memctl_r, memctl_nxt;
	logic stack_overflow_reset_enable_r, stack_overflow_reset_enable_nxt;
	logic stk_we;
	logic [PCRS_SP_W-1:0] stk_wa;
	logic [PCRS_PC_W-1:0] stk_wd, top_of_stack_entry;
	logic awr_nxt, bv_nxt, arr_nxt, rv_nxt;
	logic [1:0] bresp_nxt, rresp_nxt;
	logic [31:0] rdata_nxt;
	logic wr_fire, rd_fire, wr_b0, pcl_wr, pcl_rd;
	logic [PCRS_ADDR_W-1:0] wa;
	logic [7:0] wd;
	logic do_push, do_pop;
	logic [PCRS_PC_W-1:0] push_val;
	logic [1:0] memory_bus_config_field;
	logic int_only, above_top;
	logic [PCRS_PC_W-1:0] ext_full;
	logic [PCRS_EXT_W-1:0] ext_mask;

	// Top-of-stack view; pointer zero has no entry and reads zero.
	assign top_of_stack_entry = (sp_r == PCRS_SP_ZERO) ? PCRS_PC_ZERO : stk[sp_r];
	assign wr_fire = s_axi_awready;
	assign rd_fire = s_axi_arready;
	assign wa = s_axi_awaddr;
	assign wd = s_axi_wdata[7:0];
	assign wr_b0 = wr_fire && s_axi_wstrb[0];
	assign pcl_wr = wr_b0 && (wa == PCRS_OFS_PCL);
	assign pcl_rd = rd_fire && (s_axi_araddr == PCRS_OFS_PCL);

	// Bus slave: both write channels are taken together, one cycle after both are valid.
	always_comb begin
		awr_nxt = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
		bv_nxt = s_axi_bvalid ? !s_axi_bready : wr_fire;
		bresp_nxt = s_axi_bresp;
		if (wr_fire) begin
			bresp_nxt = (wa > PCRS_OFS_STKCFG || wa[1:0] != 2'b00) ? PCRS_RESP_SLVERR : PCRS_RESP_OKAY;
		end
		arr_nxt = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
		rv_nxt = s_axi_rvalid ? !s_axi_rready : rd_fire;
		rresp_nxt = s_axi_rresp;
		rdata_nxt = s_axi_rdata;
		if (rd_fire) begin
			rresp_nxt = PCRS_RESP_OKAY;
			rdata_nxt = 32'h00000000;
			case (s_axi_araddr)
				PCRS_OFS_CFG: rdata_nxt[7:0] = cfg_r & PCRS_CFG_MASK;
				PCRS_OFS_MEMCTL: rdata_nxt[7:0] = memctl_r;
				PCRS_OFS_PCL: rdata_nxt[7:0] = pc_r[7:0];
				PCRS_OFS_LATH: rdata_nxt[7:0] = lath_r;
				PCRS_OFS_LATU: rdata_nxt[4:0] = latu_r;
				PCRS_OFS_SPTR: rdata_nxt[7:0] = {full_r, unf_r, 1'b0, sp_r};
				PCRS_OFS_TOSL: rdata_nxt[7:0] = top_of_stack_entry[7:0];
				PCRS_OFS_TOSH: rdata_nxt[7:0] = top_of_stack_entry[15:8];
				PCRS_OFS_TOSU: rdata_nxt[4:0] = top_of_stack_entry[20:16];
				PCRS_OFS_STKCFG: rdata_nxt[0] = stack_overflow_reset_enable_r;
				default: rresp_nxt = PCRS_RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= PCRS_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= PCRS_RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
		end else begin
			s_axi_awready <= awr_nxt;
			s_axi_wready <= awr_nxt;
			s_axi_bvalid <= bv_nxt;
			s_axi_bresp <= bresp_nxt;
			s_axi_arready <= arr_nxt;
			s_axi_rvalid <= rv_nxt;
			s_axi_rresp <= rresp_nxt;
			s_axi_rdata <= rdata_nxt;
		end
	end

	// Counter, latches, stack and configuration; software first, then hardware so sets win.
	always_comb begin
		pc_nxt = pc_r;
		sp_nxt = sp_r;
		full_nxt = full_r;
		unf_nxt = unf_r;
		lath_nxt = lath_r;
		latu_nxt = latu_r;
		cfg_nxt = cfg_r;
		cfg_done_nxt = cfg_done_r;
		memctl_nxt = memctl_r;
		stack_overflow_reset_enable_nxt = stack_overflow_reset_enable_r;
		rstq_nxt = 1'b0;
		stk_we = 1'b0;
		stk_wa = sp_r;
		stk_wd = top_of_stack_entry;
		do_push = (op == PCRS_OP_CALL || op == PCRS_OP_IRQ) && !pcl_wr;
		do_pop = (op == PCRS_OP_RET || (op == PCRS_OP_LINK && ext_set_en)) && !pcl_wr;
		push_val = (op == PCRS_OP_CALL) ? pc_r + PCRS_PC_STEP : pc_r;
		if (pcl_rd) begin
			lath_nxt = pc_r[15:8];
			latu_nxt = pc_r[20:16];
		end
		if (wr_b0) begin
			case (wa)
				PCRS_OFS_CFG: begin
					if (!cfg_done_r) begin
						cfg_nxt = wd & PCRS_CFG_MASK;
						cfg_done_nxt = 1'b1;
					end
				end
				PCRS_OFS_MEMCTL: memctl_nxt = wd & PCRS_MEMCTL_MASK;
				PCRS_OFS_PCL: pc_nxt = {latu_r, lath_r, wd[7:1], 1'b0};
				PCRS_OFS_LATH: lath_nxt = wd;
				PCRS_OFS_LATU: latu_nxt = wd[4:0] & PCRS_LATU_MASK;
				PCRS_OFS_SPTR: begin
					sp_nxt = wd[PCRS_SP_W-1:0];
					full_nxt = full_r && wd[PCRS_SPTR_FULL];
					unf_nxt = unf_r && wd[PCRS_SPTR_UNF];
				end
				PCRS_OFS_TOSL: begin
					stk_we = (sp_r != PCRS_SP_ZERO);
					stk_wd[7:0] = wd;
				end
				PCRS_OFS_TOSH: begin
					stk_we = (sp_r != PCRS_SP_ZERO);
					stk_wd[15:8] = wd;
				end
				PCRS_OFS_TOSU: begin
					stk_we = (sp_r != PCRS_SP_ZERO);
					stk_wd[20:16] = wd[4:0];
				end
				PCRS_OFS_STKCFG: stack_overflow_reset_enable_nxt = wd[0];
				default: stk_we = 1'b0;
			endcase
		end
		if (!pcl_wr) begin
			case (op)
				PCRS_OP_SEQ: pc_nxt = pc_r + PCRS_PC_STEP;
				PCRS_OP_JUMP, PCRS_OP_CALL, PCRS_OP_IRQ: begin
					pc_nxt = {op_target[PCRS_PC_W-1:1], 1'b0};
				end
				PCRS_OP_LINK: if (!ext_set_en) pc_nxt = pc_r + PCRS_PC_STEP;
				default: pc_nxt = pc_nxt;
			endcase
		end
		if (do_push) begin
			if (sp_r == PCRS_SP_TOP) begin
				sp_nxt = sp_r;
				full_nxt = 1'b1;
			end else begin
				sp_nxt = sp_r + PCRS_SP_ONE;
				stk_we = 1'b1;
				stk_wa = sp_r + PCRS_SP_ONE;
				stk_wd = push_val;
				if (sp_r + PCRS_SP_ONE == PCRS_SP_TOP) begin
					full_nxt = 1'b1;
					rstq_nxt = stack_overflow_reset_enable_r;
				end
			end
		end else if (do_pop) begin
			if (sp_r == PCRS_SP_ZERO) begin
				pc_nxt = PCRS_PC_ZERO;
				sp_nxt = PCRS_SP_ZERO;
				unf_nxt = 1'b1;
				rstq_nxt = stack_overflow_reset_enable_r;
			end else begin
				pc_nxt = top_of_stack_entry;
				sp_nxt = sp_r - PCRS_SP_ONE;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pc_r <= PCRS_PC_ZERO;
			sp_r <= PCRS_SP_ZERO;
			lath_r <= 8'h00;
			latu_r <= 5'h00;
			cfg_r <= PCRS_CFG_RST;
			cfg_done_r <= 1'b0;
			memctl_r <= 8'h00;
			stack_overflow_reset_enable_r <= PCRS_STACK_OVERFLOW_RESET_ENABLE_RST;
			stack_reset_req_r <= 1'b0;
			if (por) begin
				full_r <= 1'b0;
				unf_r <= 1'b0;
			end
		end else begin
			pc_r <= pc_nxt;
			sp_r <= sp_nxt;
			full_r <= full_nxt;
			unf_r <= unf_nxt;
			lath_r <= lath_nxt;
			latu_r <= latu_nxt;
			cfg_r <= cfg_nxt;
			cfg_done_r <= cfg_done_nxt;
			memctl_r <= memctl_nxt;
			stack_overflow_reset_enable_r <= stack_overflow_reset_enable_nxt;
			stack_reset_req_r <= rstq_nxt;
		end
		if (stk_we) stk[stk_wa] <= stk_wd;
	end

	// Fetch and external bus steering, registered from the current counter.
	always_comb begin
		memory_bus_config_field = HAS_EXT_BUS ? cfg_r[PCRS_CFG_EMB_LO+:2] : PCRS_EMB_INT;
		int_only = (memory_bus_config_field == PCRS_EMB_INT);
		above_top = (pc_r >= ONCHIP_BYTES);
		ext_full = cfg_r[PCRS_CFG_SHIFT] ? pc_r - ONCHIP_BYTES : pc_r;
		case (memory_bus_config_field)
			PCRS_EMB_A12: ext_mask = PCRS_MASK_A12;
			PCRS_EMB_A16: ext_mask = PCRS_MASK_A16;
			default: ext_mask = PCRS_MASK_A20;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pc_out_r <= PCRS_PC_ZERO;
			fetch_ext_r <= 1'b0;
			fetch_nop_r <= 1'b0;
			ext_addr_r <= 20'h00000;
			ext_bus_en_r <= 1'b0;
			bus16_r <= 1'b0;
			wait_en_r <= 1'b0;
			wait_cnt_r <= 2'b00;
			tbl_ext_r <= 1'b0;
			tbl_blocked_r <= 1'b0;
		end else begin
			pc_out_r <= pc_r;
			fetch_ext_r <= !int_only && above_top;
			fetch_nop_r <= int_only && above_top;
			ext_addr_r <= (!int_only && above_top) ? ext_full[PCRS_EXT_W-1:0] & ext_mask : 20'h00000;
			ext_bus_en_r <= !int_only;
			bus16_r <= cfg_r[PCRS_CFG_BW];
			wait_en_r <= !cfg_r[PCRS_CFG_WAIT];
			wait_cnt_r <= memctl_r[PCRS_MEMCTL_WAIT_LO+:2];
			tbl_ext_r <= tbl_req && !int_only && (tbl_addr >= ONCHIP_BYTES);
			tbl_blocked_r <= tbl_req && int_only && (tbl_addr >= ONCHIP_BYTES);
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	a_push_step: assert property (do_push && sp_r < 5'h1e |=> sp_r == $past(sp_r) + 5'h01)
		else $error("push did not advance the pointer by one");
	a_pop_value: assert property (do_pop && sp_r != 5'h00 |=> pc_r == $past(top_of_stack_entry))
		else $error("pop did not load the top entry");
	a_unf_zero: assert property (do_pop && sp_r == 5'h00 |=> unf_r && pc_r == 21'h0 && sp_r == 5'h0)
		else $error("pop at zero mishandled");
	a_full_hold: assert property (do_push && sp_r == 5'h1f |=> full_r && sp_r == 5'h1f)
		else $error("overflow moved the pointer");
	a_pc_even: assert property (pc_r[0] == 1'b0)
		else $error("counter bit 0 set");
	a_lat_call: assert property ((do_push || do_pop) && !pcl_rd && !wr_b0 |=> $stable(lath_r) && $stable(latu_r))
		else $error("call or return touched the latches");
	a_pcl_load: assert property (pcl_wr |=> pc_r[20:16] == $past(latu_r) && pc_r[15:8] == $past(lath_r))
		else $error("low byte write did not merge the latches");
	a_nop_mode: assert property (int_only && above_top |=> fetch_nop_r && !fetch_ext_r)
		else $error("internal-only fetch above top not blanked");
	a_cfg_once: assert property (cfg_done_r |=> $stable(cfg_r))
		else $error("configuration changed after first write");
	a_full_set: assert property (do_push && sp_r == 5'h1e |=> full_r && stack_reset_req_r == $past(stack_overflow_reset_enable_r))
		else $error("thirty-first push did not set full");
endmodule : pcrs_top
`default_nettype wire

// [tb/pcrs_ext_mem.sv]
// External program memory model that answers fetches on the extended bus.
// Assumes the fetch address is valid in the cycle its enable is high.
`timescale 1ns/100ps
`default_nettype none
module pcrs_ext_mem (
	// Clock.
	input wire logic clk,
	// Fetch request.
	input wire logic fetch_ext,
	input wire logic [19:0] ext_addr,
	// Read data.
	output logic [15:0] rd_data
);
	logic [15:0] last_word;

	// A deselected memory lets the bus float, so it shows the inverse of the last word.
	always @(posedge clk) begin
		if (fetch_ext) begin
			last_word <= ext_addr[15:0] ^ 16'ha5c3;
			rd_data <= ext_addr[15:0] ^ 16'ha5c3;
		end else begin
			rd_data <= ~last_word;
		end
	end
endmodule : pcrs_ext_mem
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the program counter and return stack block.
// Assumes the register slave answers as its AXI4-Lite contract describes.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import pcrs_pkg::*;
	localparam logic [20:0] ONCHIP = 21'h010000;
	localparam logic [19:0] MSK [4] = '{PCRS_MASK_A20, PCRS_MASK_A16, PCRS_MASK_A12, 20'h0};
	typedef struct {string nm; logic [31:0] v;} pcrs_exp_t;
	pcrs_exp_t exp_q [$];
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic por = 1'b1;
	pcrs_op_t op = PCRS_OP_NONE;
	logic [20:0] op_target = 21'h0;
	logic ext_set_en = 1'b0;
	logic tbl_req = 1'b0;
	logic [20:0] tbl_addr = 21'h0;
	logic [7:0] s_axi_awaddr = 8'h0;
	logic [7:0] s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic rq_seen = 1'b0;
	wire logic [20:0] pc_out_r;
	wire logic [19:0] ext_addr_r;
	wire logic [1:0] wait_cnt_r, s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic [15:0] mem_data;
	wire logic fetch_ext_r, fetch_nop_r, ext_bus_en_r, bus16_r, wait_en_r, tbl_ext_r;
	wire logic tbl_blocked_r, stack_reset_req_r, s_axi_awready, s_axi_wready;
	wire logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;

	pcrs_top #(.ONCHIP_BYTES(ONCHIP), .HAS_EXT_BUS(1'b1)) u_pcrs_top (
		.clk, .srst, .por, .op, .op_target, .ext_set_en, .tbl_req, .tbl_addr,
		.pc_out_r, .fetch_ext_r, .fetch_nop_r, .ext_addr_r, .ext_bus_en_r, .bus16_r,
		.wait_en_r, .wait_cnt_r, .tbl_ext_r, .tbl_blocked_r, .stack_reset_req_r,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready
	);
	pcrs_ext_mem u_pcrs_ext_mem (.clk(clk), .fetch_ext(fetch_ext_r), .ext_addr(ext_addr_r),
		.rd_data(mem_data));

	always #5 clk = ~clk;

	task automatic give_verdict();
		if (num_errors == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : give_verdict

	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic do_reset();
		srst <= 1'b1;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
	endtask : do_reset

	task automatic wr(logic [7:0] a, logic [7:0] d, logic [1:0] rsp);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge clk); while (s_axi_awready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge clk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		check("bresp", 32'(s_axi_bresp), 32'(rsp));
		@(posedge clk);
	endtask : wr

	// Read data is compared by the monitor below; the response code here.
	task automatic rd(logic [7:0] a, logic [31:0] exp, logic [1:0] rsp, string nm);
		exp_q.push_back('{nm, exp});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		check("rresp", 32'(s_axi_rresp), 32'(rsp));
		@(posedge clk);
	endtask : rd

	task automatic do_op(pcrs_op_t o, logic [20:0] t);
		op <= o;
		op_target <= t;
		@(posedge clk);
		op <= PCRS_OP_NONE;
		repeat (2) @(posedge clk);
	endtask : do_op

	always @(posedge clk) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
			if (exp_q.size() == 0) begin
				num_errors++;
				$display("[ERR] rdata expected none seen %h", s_axi_rdata);
			end else begin
				check(exp_q[0].nm, s_axi_rdata, exp_q[0].v);
				void'(exp_q.pop_front());
			end
		end
		if (stack_reset_req_r === 1'b1) begin
			rq_seen <= 1'b1;
		end
		cycles++;
		if (cycles > 20000) begin
			num_errors++;
			give_verdict();
		end
	end

	initial begin : main
		logic [7:0] cfg;
		logic [7:0] w;
		logic [20:0] t;
		logic [20:0] p;
		logic [19:0] e;
		logic ext;
		logic [20:0] stk [32];
		void'($urandom(32'h8759));
		do_reset();
		rd(PCRS_OFS_CFG, 32'h000000f8, PCRS_RESP_OKAY, "cfg_rst");
		rd(8'h40, 32'h0, PCRS_RESP_SLVERR, "unmapped");
		wr(8'h44, 8'h55, PCRS_RESP_SLVERR);
		for (int i = 0; i < 4; i++) begin
			do_reset();
			cfg = 8'($urandom());
			cfg[5:4] = 2'(i);
			cfg[3] = i[0];
			wr(PCRS_OFS_CFG, cfg, PCRS_RESP_OKAY);
			wr(PCRS_OFS_CFG, ~cfg, PCRS_RESP_OKAY);
			rd(PCRS_OFS_CFG, {24'h0, cfg & 8'hf8}, PCRS_RESP_OKAY, "cfg");
			w = 8'($urandom());
			wr(PCRS_OFS_MEMCTL, w, PCRS_RESP_OKAY);
			t = ONCHIP + {5'h0, 16'($urandom())};
			t[0] = 1'b0;
			tbl_req <= 1'b1;
			tbl_addr <= t;
			do_op(PCRS_OP_JUMP, t | 21'h1);
			ext = (i != 3);
			e = 20'(cfg[3] ? t - ONCHIP : t) & MSK[i];
			check("pc", 32'(pc_out_r), 32'(t));
			check("wait_cnt", 32'(wait_cnt_r), 32'(w[5:4]));
			check("wait_en", 32'(wait_en_r), 32'(!cfg[7]));
			check("bus16", 32'(bus16_r), 32'(cfg[6]));
			check("ext_bus", 32'(ext_bus_en_r), 32'(ext));
			check("fetch_ext", 32'(fetch_ext_r), 32'(ext));
			check("fetch_nop", 32'(fetch_nop_r), 32'(!ext));
			check("ext_addr", 32'(ext_addr_r), ext ? 32'(e) : 32'h0);
			check("tbl_ext", 32'(tbl_ext_r), 32'(ext));
			check("tbl_blk", 32'(tbl_blocked_r), 32'(!ext));
			@(posedge clk);
			if (ext) begin
				check("mem_data", 32'(mem_data), 32'(e[15:0] ^ 16'ha5c3));
			end
			tbl_req <= 1'b0;
		end
		do_reset();
		wr(PCRS_OFS_STKCFG, 8'h00, PCRS_RESP_OKAY);
		rd(PCRS_OFS_SPTR, 32'h0, PCRS_RESP_OKAY, "sp_rst");
		p = 21'h0;
		for (int k = 1; k < 33; k++) begin
			t = 21'($urandom()) & 21'h1ffffe;
			if (k < 32) begin
				stk[k] = p + PCRS_PC_STEP;
			end
			do_op(PCRS_OP_CALL, t);
			if (k < 32) begin
				p = t;
				check("pc_call", 32'(pc_out_r), 32'(p));
			end
		end
		rd(PCRS_OFS_SPTR, 32'h9f, PCRS_RESP_OKAY, "sp_full");
		rd(PCRS_OFS_TOSL, 32'(stk[31][7:0]), PCRS_RESP_OKAY, "tosl");
		rd(PCRS_OFS_TOSH, 32'(stk[31][15:8]), PCRS_RESP_OKAY, "tosh");
		rd(PCRS_OFS_TOSU, 32'(stk[31][20:16]), PCRS_RESP_OKAY, "tosu");
		rd(PCRS_OFS_LATH, 32'h0, PCRS_RESP_OKAY, "lath_call");
		ext_set_en <= 1'b1;
		for (int k = 31; k > 0; k--) begin
			do_op(k[0] ? PCRS_OP_RET : PCRS_OP_LINK, 21'h0);
			check("pc_pop", 32'(pc_out_r), 32'(stk[k]));
		end
		do_op(PCRS_OP_RET, 21'h0);
		check("pc_unf", 32'(pc_out_r), 32'h0);
		rd(PCRS_OFS_SPTR, 32'hc0, PCRS_RESP_OKAY, "sp_unf");
		// A reset that is not a power-on reset leaves both stack flags set.
		por <= 1'b0;
		do_reset();
		por <= 1'b1;
		rd(PCRS_OFS_SPTR, 32'hc0, PCRS_RESP_OKAY, "sp_keep");
		wr(PCRS_OFS_SPTR, 8'h00, PCRS_RESP_OKAY);
		rd(PCRS_OFS_SPTR, 32'h0, PCRS_RESP_OKAY, "sp_clr");
		ext_set_en <= 1'b0;
		do_op(PCRS_OP_LINK, 21'h0);
		do_op(PCRS_OP_SEQ, 21'h0);
		check("pc_seq", 32'(pc_out_r), 32'h4);
		wr(PCRS_OFS_STKCFG, 8'h01, PCRS_RESP_OKAY);
		rq_seen = 1'b0;
		do_op(PCRS_OP_RET, 21'h0);
		check("rst_req", 32'(rq_seen), 32'h1);
		wr(PCRS_OFS_LATH, 8'h5a, PCRS_RESP_OKAY);
		wr(PCRS_OFS_LATU, 8'h13, PCRS_RESP_OKAY);
		wr(PCRS_OFS_PCL, 8'h37, PCRS_RESP_OKAY);
		check("pc_pcl", 32'(pc_out_r), 32'h135a36);
		t = 21'($urandom()) & 21'h1ffffe;
		do_op(PCRS_OP_JUMP, t);
		rd(PCRS_OFS_PCL, 32'(t[7:0]), PCRS_RESP_OKAY, "pcl");
		rd(PCRS_OFS_LATH, 32'(t[15:8]), PCRS_RESP_OKAY, "lath");
		rd(PCRS_OFS_LATU, 32'(t[20:16]), PCRS_RESP_OKAY, "latu");
		do_op(PCRS_OP_CALL, 21'h000100);
		rd(PCRS_OFS_LATH, 32'(t[15:8]), PCRS_RESP_OKAY, "lath_keep");
		repeat (4) @(posedge clk);
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
